/* design/bci_pkg.sv */
package bci_pkg;
	// Register offsets (byte addresses of the configuration header)
	localparam logic [11:0] OFS_IRQ_PIN = 12'h03D;
	localparam logic [11:0] OFS_BRIDGE_CTRL = 12'h03E;
	localparam logic [11:0] OFS_PORT_TYPE = 12'h042;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h100;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h104;
	localparam logic [11:0] OFS_ERR_ENABLE = 12'h108;

	// Bridge control field positions
	localparam int BC_PARITY = 0;
	localparam int BC_SERR = 1;
	localparam int BC_ISA = 2;
	localparam int BC_VGA = 3;
	localparam int BC_VGA16 = 4;
	localparam int BC_SBR = 6;
	localparam logic [15:0] BC_WRITE_MASK = 16'h005F;
	localparam logic [15:0] BC_RESET = 16'h0000;
	localparam logic [7:0] IRQ_PIN_RESET = 8'h00;
	localparam logic [7:0] IRQ_PIN_NONE = 8'h00;
	localparam logic [7:0] IRQ_PIN_INTA = 8'h01;
	localparam logic [7:0] IRQ_PIN_INTD = 8'h04;

	// Port type codes
	localparam logic [3:0] PORT_TYPE_UP = 4'h5;
	localparam logic [3:0] PORT_TYPE_DOWN = 4'h6;

	// Event status bits
	localparam int EV_SBR = 0;
	localparam int EV_ERR_DROP = 1;
	localparam int EV_HOTPLUG = 2;
	localparam int EV_MEM_ERR = 3;
	localparam int EV_WIDTH = 4;

	// Secondary bus reset pulse length
	localparam int SBR_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SBR_CYCLES = (SBR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Address windows
	localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
	localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;
	localparam logic [15:0] VGA_IO_A_LO = 16'h03B0;
	localparam logic [15:0] VGA_IO_A_HI = 16'h03BB;
	localparam logic [15:0] VGA_IO_B_LO = 16'h03C0;
	localparam logic [15:0] VGA_IO_B_HI = 16'h03DF;
	localparam logic [9:0] ISA_ALIAS_LO = 10'h100;
	localparam logic [31:0] IO_64K_LIMIT = 32'h0000FFFF;

	typedef struct packed {
		logic [31:0] addr;
		logic is_io;
		logic valid;
	} bci_req_type;

	typedef struct packed {
		logic fwd_down;
		logic fwd_up;
	} bci_route_type;

	typedef struct packed {
		logic cmd_serr;
		logic dev_cor;
		logic dev_nonfatal;
		logic dev_fatal;
	} bci_err_en_type;

	typedef enum logic [1:0] {
		SBR_IDLE = 2'b00,
		SBR_ACTIVE = 2'b01,
		SBR_DONE = 2'b11
	} bci_sbr_state_type;
endpackage

/* design/bci_route.sv */
`timescale 1ns/1ps
module bci_route (
	input wire logic core_clk,
	input wire logic sys_rst,
	input bci_pkg::bci_req_type req,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_limit,
	input wire logic isa_en,
	input wire logic vga_en,
	input wire logic vga16_en,
	output bci_pkg::bci_route_type route
);
	bci_pkg::bci_route_type route_reg, route_next;
	logic in_win;
	logic isa_hit;
	logic vga_hit;
	logic [15:0] vio;

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		in_win = in_range(req.addr, io_base, io_limit);
		// Top 768 bytes of each 1 KB block below 64 KB
		isa_hit = in_win && (req.addr <= bci_pkg::IO_64K_LIMIT) && (req.addr[9:0] >= bci_pkg::ISA_ALIAS_LO);
		// 10-bit decode aliases, 16-bit decode does not
		vio = vga16_en ? req.addr[15:0] : {6'h00, req.addr[9:0]};
		if (!req.is_io) begin
			vga_hit = in_range(req.addr, bci_pkg::VGA_MEM_LO, bci_pkg::VGA_MEM_HI);
		end else begin
			vga_hit = (vga16_en ? (req.addr[31:16] == 16'h0000) : 1'b1)
				&& (in_range({16'h0000, vio}, {16'h0000, bci_pkg::VGA_IO_A_LO}, {16'h0000, bci_pkg::VGA_IO_A_HI})
				|| in_range({16'h0000, vio}, {16'h0000, bci_pkg::VGA_IO_B_LO}, {16'h0000, bci_pkg::VGA_IO_B_HI}));
		end
		route_next = '0;
		if (req.valid) begin
			if (vga_en && vga_hit) begin
				route_next.fwd_down = 1'b1;
			end else if (req.is_io && in_win) begin
				if (isa_en && isa_hit) begin
					route_next.fwd_up = 1'b1;
				end else begin
					route_next.fwd_down = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			route_reg <= '0;
		end else begin
			route_reg <= route_next;
		end
	end

	assign route = route_reg;
endmodule

/* design/bci_sbr.sv */
`timescale 1ns/1ps
module bci_sbr (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic is_upstream,
	output logic sbr_up,
	output logic sbr_down,
	output logic done
);
	bci_pkg::bci_sbr_state_type state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic up_reg, up_next;
	logic down_reg, down_next;
	logic done_reg, done_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		up_next = 1'b0;
		down_next = 1'b0;
		done_next = 1'b0;
		unique case (state_reg)
			bci_pkg::SBR_IDLE: begin
				if (start) begin
					state_next = bci_pkg::SBR_ACTIVE;
					cnt_next = 8'(bci_pkg::SBR_CYCLES - 1);
					up_next = is_upstream;
					down_next = !is_upstream;
				end
			end
			bci_pkg::SBR_ACTIVE: begin
				up_next = up_reg;
				down_next = down_reg;
				if (cnt_reg == 8'h00) begin
					state_next = bci_pkg::SBR_DONE;
					up_next = 1'b0;
					down_next = 1'b0;
					done_next = 1'b1;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			bci_pkg::SBR_DONE: begin
				if (!start) begin
					state_next = bci_pkg::SBR_IDLE;
				end
			end
			default: begin
				state_next = bci_pkg::SBR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= bci_pkg::SBR_IDLE;
			cnt_reg <= 8'h00;
			up_reg <= 1'b0;
			down_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			up_reg <= up_next;
			down_reg <= down_next;
			done_reg <= done_next;
		end
	end

	assign sbr_up = up_reg;
	assign sbr_down = down_reg;
	assign done = done_reg;
endmodule

/* design/bci_bridge_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Pin select resets zero; zero means no legacy INTA, irq still fires
// - Codes one to four name INTA to INTD
// - Only INTA supported; zero and one valid
// - Interrupts carry SBR done, dropped-error, hot-plug (downstream only) or memory-error (upstream only) events
// - Bit 1 forwards or drops secondary errors
// - Forwarding also needs error reporting enabled
// - ISA clear: forward whole I/O window down
// - ISA set: ISA aliases in window go up
// - Bit 3 forwards VGA addresses downstream
// - Bit 4 picks 10 or 16-bit decode
// - Bit 6 starts role-specific secondary bus reset
// - Config registers except the SBR bit and status hold during secondary reset
// - Parity response bit stored, no effect
// - Read-only port type selects reset variant
module bci_bridge_ctrl #(
	parameter bit IS_UPSTREAM = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input bci_pkg::bci_req_type req,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_limit,
	output bci_pkg::bci_route_type route,
	input wire logic sec_err_cor,
	input wire logic sec_err_nonfatal,
	input wire logic sec_err_fatal,
	output logic pri_err_cor,
	output logic pri_err_nonfatal,
	output logic pri_err_fatal,
	input wire logic hotplug_event,
	input wire logic mem_err_event,
	output logic irq,
	output logic legacy_inta,
	output logic sbr_up,
	output logic sbr_down
);
	logic [7:0] legacy_irq_pin_select_reg, legacy_irq_pin_select_next;
	logic [15:0] bridge_ctrl_reg, bridge_ctrl_next;
	logic [bci_pkg::EV_WIDTH-1:0] status_reg, status_next;
	logic [bci_pkg::EV_WIDTH-1:0] mask_reg, mask_next;
	bci_pkg::bci_err_en_type err_en_reg, err_en_next;
	logic [31:0] rdata_reg, rdata_next;
	logic cor_reg, cor_next;
	logic nonfatal_reg, nonfatal_next;
	logic fatal_reg, fatal_next;
	logic irq_reg, irq_next;
	logic inta_reg, inta_next;
	logic [bci_pkg::EV_WIDTH-1:0] events;
	logic any_sec_err;
	logic fwd_ok;
	logic sbr_done;
	logic sbr_up_w;
	logic sbr_down_w;
	logic [3:0] port_type;

	assign port_type = IS_UPSTREAM ? bci_pkg::PORT_TYPE_UP : bci_pkg::PORT_TYPE_DOWN;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// Register bank
	always_comb begin
		legacy_irq_pin_select_next = legacy_irq_pin_select_reg;
		bridge_ctrl_next = bridge_ctrl_reg;
		mask_next = mask_reg;
		err_en_next = err_en_reg;
		if (reg_wr) begin
			if (hit(reg_addr, bci_pkg::OFS_IRQ_PIN)) begin
				// Only none and INTA are kept; other codes fall back to none
				if (reg_wdata[7:0] == bci_pkg::IRQ_PIN_INTA) begin
					legacy_irq_pin_select_next = bci_pkg::IRQ_PIN_INTA;
				end else begin
					legacy_irq_pin_select_next = bci_pkg::IRQ_PIN_NONE;
				end
			end
			if (hit(reg_addr, bci_pkg::OFS_BRIDGE_CTRL)) begin
				bridge_ctrl_next = reg_wdata[15:0] & bci_pkg::BC_WRITE_MASK;
			end
			if (hit(reg_addr, bci_pkg::OFS_IRQ_MASK)) begin
				mask_next = reg_wdata[bci_pkg::EV_WIDTH-1:0];
			end
			if (hit(reg_addr, bci_pkg::OFS_ERR_ENABLE)) begin
				err_en_next = reg_wdata[3:0];
			end
		end
		// Other settings are frozen while a secondary reset runs
		if (sbr_up_w || sbr_down_w) begin
			legacy_irq_pin_select_next = legacy_irq_pin_select_reg;
			mask_next = mask_reg;
			err_en_next = err_en_reg;
			bridge_ctrl_next = bridge_ctrl_reg;
			if (reg_wr && hit(reg_addr, bci_pkg::OFS_BRIDGE_CTRL)) begin
				bridge_ctrl_next[bci_pkg::BC_SBR] = reg_wdata[bci_pkg::BC_SBR];
			end
		end
	end

	// Event status, write one to clear, set wins
	always_comb begin
		events = '0;
		events[bci_pkg::EV_SBR] = sbr_done;
		events[bci_pkg::EV_ERR_DROP] = any_sec_err && !fwd_ok;
		events[bci_pkg::EV_HOTPLUG] = hotplug_event && !IS_UPSTREAM;
		events[bci_pkg::EV_MEM_ERR] = mem_err_event && IS_UPSTREAM;
		status_next = status_reg;
		if (reg_wr && hit(reg_addr, bci_pkg::OFS_IRQ_STATUS)) begin
			status_next = status_reg & ~reg_wdata[bci_pkg::EV_WIDTH-1:0];
		end
		status_next = status_next | events;
		irq_next = |(status_next & mask_next);
		// Legacy INTA only when pin select names INTA
		inta_next = irq_next && (legacy_irq_pin_select_next == bci_pkg::IRQ_PIN_INTA);
	end

	// Error forwarding from secondary to primary
	always_comb begin
		any_sec_err = sec_err_cor || sec_err_nonfatal || sec_err_fatal;
		fwd_ok = bridge_ctrl_reg[bci_pkg::BC_SERR];
		cor_next = fwd_ok && sec_err_cor && (err_en_reg.cmd_serr || err_en_reg.dev_cor);
		nonfatal_next = fwd_ok && sec_err_nonfatal && (err_en_reg.cmd_serr || err_en_reg.dev_nonfatal);
		fatal_next = fwd_ok && sec_err_fatal && (err_en_reg.cmd_serr || err_en_reg.dev_fatal);
	end

	// Read data, one cycle after the strobe
	always_comb begin
		rdata_next = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				bci_pkg::OFS_IRQ_PIN: rdata_next = {24'h000000, legacy_irq_pin_select_reg};
				bci_pkg::OFS_BRIDGE_CTRL: rdata_next = {16'h0000, bridge_ctrl_reg};
				bci_pkg::OFS_PORT_TYPE: rdata_next = {28'h0000000, port_type};
				bci_pkg::OFS_IRQ_STATUS: rdata_next = {28'h0000000, status_reg};
				bci_pkg::OFS_IRQ_MASK: rdata_next = {28'h0000000, mask_reg};
				bci_pkg::OFS_ERR_ENABLE: rdata_next = {28'h0000000, err_en_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			legacy_irq_pin_select_reg <= bci_pkg::IRQ_PIN_RESET;
			bridge_ctrl_reg <= bci_pkg::BC_RESET;
			status_reg <= '0;
			mask_reg <= '0;
			err_en_reg <= '0;
			rdata_reg <= 32'h00000000;
			cor_reg <= 1'b0;
			nonfatal_reg <= 1'b0;
			fatal_reg <= 1'b0;
			irq_reg <= 1'b0;
			inta_reg <= 1'b0;
		end else begin
			legacy_irq_pin_select_reg <= legacy_irq_pin_select_next;
			bridge_ctrl_reg <= bridge_ctrl_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			err_en_reg <= err_en_next;
			rdata_reg <= rdata_next;
			cor_reg <= cor_next;
			nonfatal_reg <= nonfatal_next;
			fatal_reg <= fatal_next;
			irq_reg <= irq_next;
			inta_reg <= inta_next;
		end
	end

	bci_route u_route (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(req),
		.io_base(io_base),
		.io_limit(io_limit),
		.isa_en(bridge_ctrl_reg[bci_pkg::BC_ISA]),
		.vga_en(bridge_ctrl_reg[bci_pkg::BC_VGA]),
		.vga16_en(bridge_ctrl_reg[bci_pkg::BC_VGA16]),
		.route(route)
	);

	bci_sbr u_sbr (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(bridge_ctrl_reg[bci_pkg::BC_SBR]),
		.is_upstream(IS_UPSTREAM),
		.sbr_up(sbr_up_w),
		.sbr_down(sbr_down_w),
		.done(sbr_done)
	);

	assign reg_rdata = rdata_reg;
	assign pri_err_cor = cor_reg;
	assign pri_err_nonfatal = nonfatal_reg;
	assign pri_err_fatal = fatal_reg;
	assign irq = irq_reg;
	assign legacy_inta = inta_reg;
	assign sbr_up = sbr_up_w;
	assign sbr_down = sbr_down_w;
endmodule

/* tb/bci_link_model.sv */
`timescale 1ns/1ps
module bci_link_model (
	input wire logic core_clk,
	output logic err_cor,
	output logic err_nonfatal,
	output logic err_fatal
);
	logic [2:0] msg = 3'h0;
	// One error message per call, one cycle long, after an optional idle gap
	task automatic send_msg(input logic [2:0] kind, input int gap);
		repeat (gap) @(posedge core_clk);
		msg <= kind;
		@(posedge core_clk);
		msg <= 3'h0;
	endtask
	assign err_cor = msg[2];
	assign err_nonfatal = msg[1];
	assign err_fatal = msg[0];
endmodule

/* tb/bci_bridge_ctrl_assertions.sv */
`timescale 1ns/1ps
module bci_check #(
	parameter bit IS_UPSTREAM = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input bci_pkg::bci_req_type req,
	input bci_pkg::bci_route_type route,
	input wire logic sec_err_cor,
	input wire logic sec_err_fatal,
	input wire logic pri_err_cor,
	input wire logic pri_err_fatal,
	input wire logic irq,
	input wire logic legacy_inta,
	input wire logic sbr_up,
	input wire logic sbr_down
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	always_comb begin
		cnt_next = (sbr_up | sbr_down) ? cnt_reg + 8'h01 : 8'h00;
	end
	always_ff @(posedge core_clk) begin
		cnt_reg <= sys_rst ? 8'h00 : cnt_next;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
	cor_fwd_a: assert property (pri_err_cor |-> $past(sec_err_cor)) else $error("unsourced cor");
	fatal_fwd_a: assert property ($rose(pri_err_fatal) |-> $past(sec_err_fatal)) else $error("unsourced fatal");
	inta_irq_a: assert property (legacy_inta |-> irq) else $error("inta without irq");
	sbr_role_a: assert property (!(IS_UPSTREAM ? sbr_down : sbr_up)) else $error("wrong reset variant");
	sbr_len_a: assert property ($fell(sbr_up | sbr_down) |-> cnt_reg == 8'h28) else $error("reset length");
	sbr_max_a: assert property ((sbr_up | sbr_down) |-> cnt_reg < 8'h28) else $error("reset too long");
	route_one_a: assert property (!(route.fwd_up && route.fwd_down)) else $error("both routes");
	route_req_a: assert property ((route.fwd_up || route.fwd_down) |-> $past(req.valid)) else $error("route w/o req");
	mem_up_a: assert property ($past(req.valid && !req.is_io) |-> !route.fwd_up) else $error("memory upstream");
	cover property ($rose(sbr_down));
	cover property (pri_err_fatal);
	cover property ($rose(legacy_inta));
	cover property (route.fwd_up);
endmodule
bind bci_bridge_ctrl bci_check #(.IS_UPSTREAM(IS_UPSTREAM)) chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .route(route), .sec_err_cor(sec_err_cor),
	.sec_err_fatal(sec_err_fatal), .pri_err_cor(pri_err_cor), .pri_err_fatal(pri_err_fatal), .irq(irq),
	.legacy_inta(legacy_inta), .sbr_up(sbr_up), .sbr_down(sbr_down));

/* tb/bci_bridge_ctrl_test.sv */
`timescale 1ns/1ps
module bci_bridge_ctrl_test;
	typedef struct packed {
		logic [15:0] bc;
		logic [31:0] addr;
		logic io;
		logic [1:0] exp;
	} bci_row_type;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	bci_pkg::bci_req_type req = '0;
	bci_pkg::bci_route_type route;
	logic s_cor;
	logic s_nf;
	logic s_fat;
	logic p_cor;
	logic p_nf;
	logic p_fat;
	logic hotplug_event = 1'b0;
	logic mem_err_event = 1'b0;
	logic irq;
	logic legacy_inta;
	logic sbr_up;
	logic sbr_down;
	int bad_count = 0;
	int comparisons = 0;
	int n;
	// Window 0x1000..0x1FFF; route is {down, up}
	bci_row_type rows [9] = '{'{16'h0000, 32'h1100, 1'b1, 2'h2}, '{16'h0000, 32'h2100, 1'b1, 2'h0},
		'{16'h0004, 32'h1100, 1'b1, 2'h1}, '{16'h0004, 32'h1050, 1'b1, 2'h2}, '{16'h0008, 32'hA0000, 1'b0, 2'h2},
		'{16'h0000, 32'hA0000, 1'b0, 2'h0}, '{16'h0008, 32'h23C0, 1'b1, 2'h2}, '{16'h0018, 32'h23C0, 1'b1, 2'h0},
		'{16'h0018, 32'h03C0, 1'b1, 2'h2}};
	bci_bridge_ctrl #(.IS_UPSTREAM(1'b0)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
		.io_base(32'h1000), .io_limit(32'h1FFF), .route(route), .sec_err_cor(s_cor), .sec_err_nonfatal(s_nf),
		.sec_err_fatal(s_fat), .pri_err_cor(p_cor), .pri_err_nonfatal(p_nf), .pri_err_fatal(p_fat),
		.hotplug_event(hotplug_event), .mem_err_event(mem_err_event), .irq(irq), .legacy_inta(legacy_inta),
		.sbr_up(sbr_up), .sbr_down(sbr_down));
	bci_link_model link_u (.core_clk(core_clk), .err_cor(s_cor), .err_nonfatal(s_nf), .err_fatal(s_fat));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Idle edge so a following write never re-drives the strobe in the same step
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
		@(posedge core_clk);
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(12'h03D, 32'h0);
		rd(12'h03E, 32'h0);
		rd(12'h042, 32'h6);
		for (int k = 0; k < 5; k++) begin
			wr(12'h03D, 32'(k));
			rd(12'h03D, (k == 1) ? 32'h1 : 32'h0);
		end
		wr(12'h03E, 32'hFFBF);
		rd(12'h03E, 32'h001F);
		wr(12'h200, 32'h1);
		rd(12'h200, 32'h0);
		foreach (rows[i]) begin
			wr(12'h03E, {16'h0, rows[i].bc});
			req <= '{rows[i].addr, rows[i].io, 1'b1};
			@(posedge core_clk);
			req <= '0;
			@(negedge core_clk);
			chk({30'h0, route}, {30'h0, rows[i].exp});
			@(posedge core_clk);
		end
		wr(12'h104, 32'hF);
		wr(12'h03D, 32'h1);
		wr(12'h03E, 32'h2);
		link_u.send_msg(3'h1, 0);
		@(negedge core_clk);
		chk(p_fat, 1'b0);
		@(posedge core_clk);
		wr(12'h100, 32'hF);
		wr(12'h108, 32'hF);
		rd(12'h108, 32'hF);
		link_u.send_msg(3'h1, 3);
		@(negedge core_clk);
		chk(p_fat, 1'b1);
		@(posedge core_clk);
		link_u.send_msg(3'h4, 0);
		@(negedge core_clk);
		chk(p_cor, 1'b1);
		@(posedge core_clk);
		wr(12'h03E, 32'h0);
		link_u.send_msg(3'h2, 1);
		@(negedge core_clk);
		chk(p_nf, 1'b0);
		@(posedge core_clk);
		rd(12'h100, 32'h2);
		@(negedge core_clk);
		chk({irq, legacy_inta}, 2'h3);
		@(posedge core_clk);
		wr(12'h104, 32'h0);
		repeat (2) @(negedge core_clk);
		chk({irq, legacy_inta}, 2'h0);
		@(posedge core_clk);
		wr(12'h104, 32'hF);
		wr(12'h100, 32'h2);
		rd(12'h100, 32'h0);
		hotplug_event <= 1'b1;
		mem_err_event <= 1'b1;
		@(posedge core_clk);
		hotplug_event <= 1'b0;
		mem_err_event <= 1'b0;
		rd(12'h100, 32'h4);
		wr(12'h03D, 32'h0);
		@(negedge core_clk);
		chk({irq, legacy_inta}, 2'h2);
		@(posedge core_clk);
		wr(12'h03D, 32'h1);
		wr(12'h100, 32'hF);
		wr(12'h03E, 32'h40);
		n = 0;
		@(negedge core_clk);
		while (sbr_down !== 1'b1 && n < 60) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 60) begin
			bad_count++;
			finish_test();
		end
		@(posedge core_clk);
		wr(12'h03D, 32'h0);
		// Cycles of the reset pulse already spent before this loop
		n = 3;
		while (n < 100) begin
			@(negedge core_clk);
			if (sbr_down !== 1'b1) break;
			n++;
		end
		chk(32'(n), 32'(bci_pkg::SBR_CYCLES));
		chk(sbr_up, 1'b0);
		@(posedge core_clk);
		rd(12'h03D, 32'h1);
		rd(12'h100, 32'h1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(12'h03E, 32'h0);
		rd(12'h03D, 32'h0);
		finish_test();
	end
endmodule
